// ---- hdl/twb_dev.sv ----
// slave end of the two-wire bus: bit engine on the link clock, user side on i_clk
// assumes the bench resolves the lines in twb_if and supplies both clocks
// Function
// - lines only pulled low or released
// - detect start: data falls, clock high
// - detect stop: data rises, clock high
// - start without stop is repeated start
// - data changes only while clock low
// - eight bits, msb first, plus acknowledge
// - ninth clock: low acknowledges, high refuses
// - master sends address and direction first
// - matching address acknowledged after direction bit
// - mismatch: stay released until next start
// - one address packet per start
// - direction zero: device receives data bytes
// - direction one: device transmits data bytes
// - data packets nine bits, direction from address
// - receiver answers every byte
// - transaction held until stop
// - stop right after address is complete
// - no limit on data packets
// - master stops after refused written byte
// - master reads only after address acknowledged
// - any party may hold clock low
// - master refuses last read byte, device releases
`timescale 1ns/10ps
`default_nettype none
module twb_dev #(
	parameter logic [6:0] OWN_ADDR = twb_pkg::OWN_ADDR_DEF
) (
	input wire logic i_clk, // user clock
	input wire logic i_rst, // synchronous reset, active high
	input wire logic i_link_clk, // bit engine clock
	twb_if.device bus, // two-wire bus
	input wire logic [7:0] i_tx_data, // byte for the master to read
	input wire logic i_tx_valid, // tx byte offered
	output logic o_tx_ready, // tx byte may be taken
	input wire logic i_rx_refuse, // refuse further written bytes
	output logic [7:0] o_rx_data, // last written byte
	output logic o_rx_valid, // one-cycle strobe for o_rx_data
	output logic o_busy // between start and stop
);
	typedef enum logic [2:0] {
		D_IDLE, D_ADDR, D_AACK, D_RX, D_RACK, D_TXW, D_TX, D_TACK
	} dst_e;

	// link-domain state
	typedef struct packed {
		logic scl1;
		logic scl2;
		logic sclq;
		logic sda1;
		logic sda2;
		logic sdaq;
		dst_e st;
		logic hold; // clock held low by the slave
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic sda_oe;
		logic busy;
		logic rx_tog;
		logic [7:0] rx_byte;
		logic [7:0] txbuf;
		logic txfull;
		logic tq1;
		logic tq2;
		logic tack;
		logic nk1;
		logic nk2;
	} lk_s;

	// user-domain state
	typedef struct packed {
		logic tx_tog;
		logic [7:0] tx_data;
		logic a1;
		logic a2;
		logic r1;
		logic r2;
		logic r3;
		logic [7:0] rx_data;
		logic rx_valid;
		logic b1;
		logic b2;
	} us_s;

	lk_s l, next_l;
	us_s u, next_u;
	logic lrst1, lrst2;
	logic rise, fall, start_c, stop_c;

	// reset carried into the link domain
	always_ff @(posedge i_link_clk) begin
		lrst1 <= i_rst;
		lrst2 <= lrst1;
	end

	// edges of the synchronised lines
	assign rise = l.scl2 & ~l.sclq;
	assign fall = ~l.scl2 & l.sclq;
	assign start_c = l.scl2 & l.sclq & l.sdaq & ~l.sda2;
	assign stop_c = l.scl2 & l.sclq & ~l.sdaq & l.sda2;

	// bit engine
	always_comb begin
		next_l = l;
		next_l.scl1 = bus.scl;
		next_l.scl2 = l.scl1;
		next_l.sclq = l.scl2;
		next_l.sda1 = bus.sda;
		next_l.sda2 = l.sda1;
		next_l.sdaq = l.sda2;
		next_l.tq1 = u.tx_tog;
		next_l.tq2 = l.tq1;
		next_l.nk1 = i_rx_refuse;
		next_l.nk2 = l.nk1;
		// clock let go a cycle after the first data bit is set up
		next_l.hold = (l.st == D_TXW);
		// take a new tx byte from the user side
		if (l.tq2 != l.tack && !l.txfull) begin
			next_l.txbuf = u.tx_data;
			next_l.txfull = 1'b1;
			next_l.tack = ~l.tack;
		end
		if (start_c) begin
			// plain or repeated start alike opens one address packet
			next_l.st = D_ADDR;
			next_l.cnt = '0;
			next_l.sda_oe = 1'b0;
			next_l.busy = 1'b1;
		end else if (stop_c) begin
			next_l.st = D_IDLE;
			next_l.sda_oe = 1'b0;
			next_l.busy = 1'b0;
		end else begin
			case (l.st)
				D_ADDR: begin
					if (rise) begin
						next_l.sh = {l.sh[6:0], l.sda2};
						next_l.cnt = l.cnt + 4'h1;
					end else if (fall && l.cnt == twb_pkg::BIT_LAST) begin
						if (l.sh[7:1] == OWN_ADDR) begin
							next_l.sda_oe = 1'b1;
							next_l.rw = l.sh[0];
							next_l.st = D_AACK;
						end else begin
							next_l.st = D_IDLE;
						end
					end
				end
				D_AACK: begin
					if (fall) begin
						next_l.sda_oe = 1'b0;
						next_l.cnt = '0;
						next_l.st = l.rw ? D_TXW : D_RX;
					end
				end
				D_TXW: begin
					// clock held low until a byte is at hand
					if (l.txfull) begin
						next_l.sh = l.txbuf;
						next_l.txfull = 1'b0;
						next_l.sda_oe = ~l.txbuf[7];
						next_l.cnt = '0;
						next_l.st = D_TX;
					end
				end
				D_TX: begin
					if (rise) begin
						next_l.cnt = l.cnt + 4'h1;
					end else if (fall) begin
						// shift only after the clock falls
						if (l.cnt == twb_pkg::BIT_LAST) begin
							next_l.sda_oe = 1'b0;
							next_l.st = D_TACK;
						end else begin
							next_l.sh = {l.sh[6:0], 1'b0};
							next_l.sda_oe = ~l.sh[6];
						end
					end
				end
				D_TACK: begin
					if (rise) begin
						next_l.sh[0] = l.sda2;
					end else if (fall) begin
						next_l.st = l.sh[0] ? D_IDLE : D_TXW;
					end
				end
				D_RX: begin
					if (rise) begin
						next_l.sh = {l.sh[6:0], l.sda2};
						next_l.cnt = l.cnt + 4'h1;
					end else if (fall && l.cnt == twb_pkg::BIT_LAST) begin
						next_l.rx_byte = l.sh;
						next_l.rx_tog = ~l.rx_tog;
						next_l.sda_oe = ~l.nk2;
						next_l.st = D_RACK;
					end
				end
				D_RACK: begin
					if (fall) begin
						next_l.sda_oe = 1'b0;
						next_l.cnt = '0;
						next_l.st = D_RX;
					end
				end
				D_IDLE: begin
					next_l.sda_oe = 1'b0;
				end
				default: begin
					next_l.st = D_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (lrst2) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	// open-drain drive, clock stretched while waiting for tx data
	assign bus.sda_d_oe = l.sda_oe;
	assign bus.scl_d_oe = l.hold;

	// user side: tx handshake and rx strobe
	always_comb begin
		next_u = u;
		next_u.a1 = l.tack;
		next_u.a2 = u.a1;
		next_u.r1 = l.rx_tog;
		next_u.r2 = u.r1;
		next_u.r3 = u.r2;
		next_u.b1 = l.busy;
		next_u.b2 = u.b1;
		next_u.rx_valid = u.r2 ^ u.r3;
		if (u.r2 ^ u.r3) begin
			next_u.rx_data = l.rx_byte;
		end
		if (i_tx_valid && o_tx_ready) begin
			next_u.tx_data = i_tx_data;
			next_u.tx_tog = ~u.tx_tog;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			u <= '0;
		end else begin
			u <= next_u;
		end
	end

	assign o_tx_ready = (u.tx_tog == u.a2);
	assign o_rx_data = u.rx_data;
	assign o_rx_valid = u.rx_valid;
	assign o_busy = u.b2;
endmodule
`default_nettype wire

// ---- hdl/twb_mst.sv ----
// master end of the two-wire bus: makes the clock by a divider of i_clk
// assumes the slave end and bench share the same twb_if instance
`timescale 1ns/10ps
`default_nettype none
module twb_mst (
	input wire logic i_clk, // master clock
	input wire logic i_rst, // synchronous reset, active high
	twb_if.master bus, // two-wire bus
	input wire logic i_cmd_valid, // command offered
	input wire logic [1:0] i_cmd, // start, write, read, stop
	input wire logic [7:0] i_wdata, // byte to write
	input wire logic i_rd_nack, // refuse the byte being read
	output logic o_cmd_ready, // command may be taken
	output logic o_done, // one-cycle strobe at end of a byte
	output logic [7:0] o_rd_data, // byte read
	output logic o_ack // ninth bit was low
);
	typedef enum logic [2:0] {
		M_IDLE, M_S1, M_RS1, M_RS2, M_LO, M_HI, M_P1, M_P2
	} mst_e;

	typedef struct packed {
		logic s1;
		logic s2;
		logic d1;
		logic d2;
		mst_e st;
		logic stp;
		logic [7:0] tmr;
		logic [3:0] cnt;
		logic [8:0] tx;
		logic [7:0] rx;
		logic scl_oe;
		logic sda_oe;
		logic owned;
		logic nak;
		logic rd;
		logic [7:0] rd_data;
		logic ack;
		logic done;
	} ms_s;

	ms_s m, next_m;
	logic tick;

	// half-bit timer, kept at zero while another party holds the released clock low
	function automatic logic [7:0] step(input logic [7:0] t);
		return (t == twb_pkg::QUART_LAST) ? 8'h00 : t + 8'h01;
	endfunction

	assign tick = (m.tmr == twb_pkg::QUART_LAST);

	always_comb begin
		next_m = m;
		next_m.s1 = bus.scl;
		next_m.s2 = m.s1;
		next_m.d1 = bus.sda;
		next_m.d2 = m.d1;
		next_m.done = 1'b0;
		next_m.tmr = step(m.tmr);
		case (m.st)
			M_IDLE: begin
				next_m.tmr = '0;
				if (i_cmd_valid) begin
					case (i_cmd)
						twb_pkg::CMD_START: begin
							next_m.nak = 1'b0;
							next_m.sda_oe = ~m.owned;
							next_m.st = m.owned ? M_RS1 : M_S1;
						end
						twb_pkg::CMD_STOP: begin
							next_m.st = m.owned ? M_P1 : M_IDLE;
						end
						default: begin
							// refused address or written byte ends the transaction
							if (m.owned && m.nak) begin
								next_m.st = M_P1;
							end else if (m.owned) begin
								next_m.rd = (i_cmd == twb_pkg::CMD_READ);
								next_m.tx = (i_cmd == twb_pkg::CMD_READ) ?
									{twb_pkg::IDLE_BYTE, i_rd_nack} : {i_wdata, 1'b1};
								next_m.cnt = '0;
								next_m.st = M_LO;
							end
						end
					endcase
				end
			end
			M_S1: begin
				next_m.sda_oe = 1'b1;
				if (tick) begin
					next_m.scl_oe = 1'b1;
					next_m.owned = 1'b1;
					next_m.st = M_IDLE;
				end
			end
			M_RS1: begin
				next_m.scl_oe = 1'b1;
				next_m.sda_oe = 1'b0;
				if (tick) begin
					next_m.scl_oe = 1'b0;
					next_m.st = M_RS2;
				end
			end
			M_RS2: begin
				if (!m.s2) begin
					next_m.tmr = '0;
				end else if (tick) begin
					next_m.sda_oe = 1'b1;
					next_m.st = M_S1;
				end
			end
			M_LO: begin
				next_m.sda_oe = ~m.tx[8];
				if (tick) begin
					next_m.scl_oe = 1'b0;
					next_m.st = M_HI;
				end
			end
			M_HI: begin
				if (!m.s2) begin
					next_m.tmr = '0;
				end else if (tick) begin
					next_m.scl_oe = 1'b1;
					next_m.cnt = m.cnt + 4'h1;
					next_m.tx = {m.tx[7:0], 1'b0};
					next_m.rx = {m.rx[6:0], m.d2};
					next_m.st = M_LO;
					if (m.cnt == twb_pkg::BIT_LAST) begin
						next_m.rx = m.rx;
						next_m.rd_data = m.rx;
						next_m.ack = ~m.d2;
						next_m.nak = ~m.rd & m.d2;
						next_m.done = 1'b1;
						next_m.st = M_IDLE;
					end
				end
			end
			M_P1: begin
				next_m.scl_oe = 1'b1;
				next_m.sda_oe = 1'b1;
				next_m.stp = 1'b0;
				if (tick) begin
					next_m.scl_oe = 1'b0;
					next_m.st = M_P2;
				end
			end
			M_P2: begin
				if (!m.s2) begin
					next_m.tmr = '0;
				end else if (tick) begin
					next_m.sda_oe = 1'b0;
					if (m.stp) begin
						next_m.owned = 1'b0;
						next_m.stp = 1'b0;
						next_m.st = M_IDLE;
					end else begin
						next_m.stp = 1'b1;
					end
				end
			end
			default: begin
				next_m.st = M_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			m <= '0;
		end else begin
			m <= next_m;
		end
	end

	assign bus.scl_m_oe = m.scl_oe;
	assign bus.sda_m_oe = m.sda_oe;
	assign o_cmd_ready = (m.st == M_IDLE);
	assign o_done = m.done;
	assign o_rd_data = m.rd_data;
	assign o_ack = m.ack;
endmodule
`default_nettype wire

// ---- shared/twb_if.sv ----
// open-drain two-wire bus joining the master end and the slave end
// assumes each party only pulls a line low; released lines read high
`timescale 1ns/10ps
`default_nettype none
interface twb_if;
	logic scl_m_oe; // master pulls clock low
	logic sda_m_oe; // master pulls data low
	logic scl_d_oe; // slave pulls clock low
	logic sda_d_oe; // slave pulls data low
	logic scl; // resolved clock line
	logic sda; // resolved data line
	// wired-and with pull-up
	assign scl = ~(scl_m_oe | scl_d_oe);
	assign sda = ~(sda_m_oe | sda_d_oe);
	modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
	modport device (output scl_d_oe, output sda_d_oe, input scl, input sda);
endinterface
`default_nettype wire

// ---- shared/twb_pkg.sv ----
// constants shared by both ends of the two-wire bus
// assumes a 100 MHz master clock and open-drain lines with pull-ups
package twb_pkg;
	localparam int CLK_NS = 10; // master clock period
	localparam int QUART_NS = 1250; // half of one bus bit period
	localparam int QUART_CYC = (QUART_NS + CLK_NS - 1) / CLK_NS; // least time, rounded up
	localparam logic [7:0] QUART_LAST = 8'(QUART_CYC - 1);
	localparam logic [3:0] BIT_LAST = 4'h8; // index of the acknowledge clock
	localparam logic [6:0] OWN_ADDR_DEF = 7'h2A; // default slave address
	localparam logic [7:0] IDLE_BYTE = 8'hFF; // released data bits of a read
	// master command codes
	localparam logic [1:0] CMD_START = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_READ = 2'h2;
	localparam logic [1:0] CMD_STOP = 2'h3;
endpackage

// ---- verif/twb_properties.sv ----
// assertions on the two-wire bus lines and the pulls of both ends, sampled on the master clock
// assumes instantiation beside the bus interface in the bench top
`timescale 1ns/10ps
`default_nettype none
module twb_properties (
	input wire logic i_clk, // sampling clock
	input wire logic i_rst, // sync reset, active high
	input wire logic scl_m_oe, // master clock pull
	input wire logic sda_m_oe, // master data pull
	input wire logic scl_d_oe, // slave clock pull
	input wire logic sda_d_oe, // slave data pull
	input wire logic scl, // resolved clock
	input wire logic sda // resolved data
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// bus conditions
	sequence s_start; $fell(sda) && scl && $past(scl); endsequence
	sequence s_stop; $rose(sda) && scl && $past(scl); endsequence
	// clock phases, slave data timing, clock after start and release after stop
	property p_hi_min; $rose(scl) |-> scl[*8]; endproperty
	property p_lo_min; $fell(scl) |-> !scl[*8]; endproperty
	property p_dev_hold; $changed(sda_d_oe) |-> !scl && !$past(scl); endproperty
	property p_dev_sync; $fell(scl) |=> $stable(sda_d_oe)[*3]; endproperty
	property p_dev_stretch; $rose(scl_d_oe) |-> !$past(scl); endproperty
	property p_start; s_start |-> scl[*8] ##[1:300] !scl; endproperty
	property p_stop_m; s_stop |-> (!scl_m_oe && !sda_m_oe)[*8]; endproperty
	property p_stop_d; s_stop |-> (!scl_d_oe && !sda_d_oe)[*8]; endproperty
	a_hi_min: assert property (p_hi_min)
		else $error("clock high phase cut short");
	a_lo_min: assert property (p_lo_min)
		else $error("clock low phase cut short");
	a_dev_hold: assert property (p_dev_hold)
		else $error("slave data moved while clock high");
	a_dev_sync: assert property (p_dev_sync)
		else $error("slave reacted before line sync");
	a_dev_stretch: assert property (p_dev_stretch)
		else $error("slave pulled clock while high");
	a_start: assert property (p_start)
		else $error("start not followed by clock");
	a_stop_m: assert property (p_stop_m)
		else $error("master drives after stop");
	a_stop_d: assert property (p_stop_d)
		else $error("slave drives after stop");
	// main scenarios reached
	c_start: cover property (s_start);
	c_stretch: cover property ($rose(scl_d_oe));
	c_ack: cover property ($rose(sda_d_oe));
endmodule
`default_nettype wire

// ---- verif/two_wire_bus_slave_protocol_tb.sv ----
// self-checking bench: master end and slave end joined on one bus
// assumes package, interface, both ends and checker compile first
`timescale 1ns/10ps
`default_nettype none
module two_wire_bus_slave_protocol_tb;
	typedef struct packed {
		logic [6:0] addr;
		logic rw;
		logic [7:0] dat;
		logic refuse;
	} row_s;
	logic i_clk = 1'h0;
	logic link_clk = 1'h0;
	logic i_rst = 1'h1;
	logic cmd_valid = 1'h0;
	logic rd_nack = 1'h0;
	logic tx_valid = 1'h0;
	logic rx_refuse = 1'h0;
	logic [1:0] cmd = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] tx_data = 8'h00;
	logic cmd_ready, done, ack, tx_ready, rx_valid, busy;
	logic [7:0] rd_data, rx_data, rxd;
	logic [8:0] sh = 9'h000;
	int rxn = 0;
	int cyc = 0;
	int fail_count = 0;
	int compares = 0;
	// address, direction, byte, refuse
	row_s rows [6] = '{'{twb_pkg::OWN_ADDR_DEF, 1'h0, 8'hA5, 1'h0},
		'{twb_pkg::OWN_ADDR_DEF, 1'h0, 8'h3C, 1'h1}, '{twb_pkg::OWN_ADDR_DEF, 1'h1, 8'hC3, 1'h0},
		'{7'h2B, 1'h0, 8'h00, 1'h0}, '{7'h15, 1'h1, 8'hFF, 1'h0},
		'{twb_pkg::OWN_ADDR_DEF, 1'h1, 8'h01, 1'h0}};
	twb_if bus ();
	twb_mst twb_mst_inst (.i_clk(i_clk), .i_rst(i_rst), .bus(bus.master), .i_cmd_valid(cmd_valid),
		.i_cmd(cmd), .i_wdata(wdata), .i_rd_nack(rd_nack), .o_cmd_ready(cmd_ready), .o_done(done),
		.o_rd_data(rd_data), .o_ack(ack));
	twb_dev twb_dev_inst (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(link_clk), .bus(bus.device),
		.i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_rx_refuse(rx_refuse),
		.o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_busy(busy));
	twb_properties twb_properties_inst (.i_clk(i_clk), .i_rst(i_rst), .scl_m_oe(bus.scl_m_oe),
		.sda_m_oe(bus.sda_m_oe), .scl_d_oe(bus.scl_d_oe), .sda_d_oe(bus.sda_d_oe),
		.scl(bus.scl), .sda(bus.sda));
	// clocks, unrelated in phase
	always #5 i_clk = ~i_clk;
	always #24 link_clk = ~link_clk;
	// wire bits at each rising bus clock
	always @(posedge bus.scl) sh <= {sh[7:0], bus.sda};
	// received bytes and watchdog, sampled clear of the launching edge
	always @(negedge i_clk) begin
		cyc <= cyc + 1;
		if (rx_valid === 1'h1) begin
			rxd <= rx_data;
			rxn <= rxn + 1;
		end
		if (cyc == 100000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic step;
		@(posedge i_clk);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'h1) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic complete_run;
		if (fail_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// one master command, waits for its end
	task automatic mcmd(input logic [1:0] c, input logic [7:0] d, input logic nk);
		while (cmd_ready !== 1'h1) step();
		cmd_valid = 1'h1;
		cmd = c;
		wdata = d;
		rd_nack = nk;
		step();
		cmd_valid = 1'h0;
		step();
		if (c == twb_pkg::CMD_WRITE || c == twb_pkg::CMD_READ) begin
			while (done !== 1'h1) step();
		end else begin
			while (cmd_ready !== 1'h1) step();
		end
	endtask
	task automatic offer(input logic [7:0] d);
		while (tx_ready !== 1'h1) step();
		tx_valid = 1'h1;
		tx_data = d;
		step();
		tx_valid = 1'h0;
		step();
	endtask
	task automatic head(input logic [6:0] a, input logic rw, input logic exp);
		mcmd(twb_pkg::CMD_START, 8'h00, 1'h0);
		mcmd(twb_pkg::CMD_WRITE, {a, rw}, 1'h0);
		chk(ack === exp, "address answer");
		chk(sh === {a, rw, !exp}, "address bits on wire");
		chk(busy === 1'h1, "busy after start");
	endtask
	task automatic rd(input logic [7:0] d, input logic nk);
		mcmd(twb_pkg::CMD_READ, 8'h00, nk);
		chk(rd_data === d, "read byte");
		chk(sh === {d, nk}, "read bits on wire");
	endtask
	task automatic wr(input logic [7:0] d);
		int n0;
		n0 = rxn;
		mcmd(twb_pkg::CMD_WRITE, d, 1'h0);
		chk(ack === !rx_refuse, "write answer");
		chk(sh === {d, rx_refuse}, "write bits on wire");
		if (!rx_refuse) chk(rxd === d && rxn == n0 + 1, "received byte");
	endtask
	task automatic tail;
		mcmd(twb_pkg::CMD_STOP, 8'h00, 1'h0);
		chk(busy === 1'h0 && bus.sda === 1'h1 && bus.scl === 1'h1, "released after stop");
	endtask
	initial begin
		row_s r;
		logic hit;
		int k;
		repeat (20) step();
		i_rst = 1'h0;
		repeat (20) step();
		chk(bus.scl === 1'h1 && bus.sda === 1'h1 && busy === 1'h0, "idle after reset");
		// ordinary transactions from the table
		foreach (rows[i]) begin
			r = rows[i];
			hit = (r.addr == twb_pkg::OWN_ADDR_DEF);
			rx_refuse = r.refuse;
			k = rxn;
			if (r.rw && hit) offer(r.dat);
			head(r.addr, r.rw, hit);
			if (hit && r.rw) rd(r.dat, 1'h1);
			if (hit && !r.rw) wr(r.dat);
			tail();
			if (!hit) chk(rxn == k, "unaddressed slave took data");
		end
		// stop straight after the address, then a long write
		rx_refuse = 1'h0;
		head(twb_pkg::OWN_ADDR_DEF, 1'h0, 1'h1);
		tail();
		head(twb_pkg::OWN_ADDR_DEF, 1'h0, 1'h1);
		for (int i = 0; i < 9; i++) wr(8'h11 * 8'(i));
		// repeated start into a read, second byte late
		offer(8'h7E);
		head(twb_pkg::OWN_ADDR_DEF, 1'h1, 1'h1);
		rd(8'h7E, 1'h0);
		fork
			rd(8'h81, 1'h1);
			begin
				repeat (600) step();
				chk(bus.scl_d_oe === 1'h1, "slave holds clock");
				offer(8'h81);
			end
		join
		tail();
		// reset with the bus owned
		head(twb_pkg::OWN_ADDR_DEF, 1'h0, 1'h1);
		i_rst = 1'h1;
		repeat (20) step();
		chk(bus.scl === 1'h1 && bus.sda === 1'h1 && busy === 1'h0, "released in reset");
		i_rst = 1'h0;
		repeat (20) step();
		head(twb_pkg::OWN_ADDR_DEF, 1'h0, 1'h1);
		wr(8'h5A);
		tail();
		complete_run();
	end
endmodule
`default_nettype wire
